// [common/aasc_pkg.sv]
// constants and types for the alert and shutdown control block
package aasc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_VOLTAGE_ALERT_LIMITS = 8'h01;
  localparam logic [7:0] ADDR_TEMPERATURE_ALERT_LIMITS = 8'h02;
  localparam logic [7:0] ADDR_CHARGE_ALERT_LIMITS = 8'h03;
  localparam logic [7:0] ADDR_TEMP = 8'h08;
  localparam logic [7:0] ADDR_CFG = 8'h1D;
  localparam logic [7:0] ADDR_SHUTDOWN_REQUEST_DLY = 8'h3F;
  // reset values and config write mask
  localparam logic [15:0] VOLTAGE_ALERT_LIMITS_RST = 16'hFF00;
  localparam logic [15:0] TEMPERATURE_ALERT_LIMITS_RST = 16'h7F80;
  localparam logic [15:0] CHARGE_ALERT_LIMITS_RST = 16'hFF00;
  localparam logic [15:0] CFG_RST = 16'h2350;
  localparam logic [15:0] CFG_WMASK = 16'h7FFF;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [2:0] THR_RST = 3'h7;
  localparam logic [7:0] TEMP_RST = 8'h00;
  // configuration bit positions
  localparam int CFG_REM_ALERT = 0;
  localparam int CFG_INS_ALERT = 1;
  localparam int CFG_THR_ALERT = 2;
  localparam int CFG_FORCE_BIAS = 3;
  localparam int CFG_AUTO_BIAS = 4;
  localparam int CFG_ALERT_SHUTDOWN_REQUEST = 5;
  localparam int CFG_BUS_SHUTDOWN_REQUEST = 6;
  localparam int CFG_SHUTDOWN_REQUEST_REQ = 7;
  localparam int CFG_HOST_TEMP = 8;
  localparam int CFG_TEMP_EN = 9;
  localparam int CFG_REM_SHUTDOWN_REQUEST = 10;
  localparam int CFG_POLARITY = 11;
  localparam int CFG_VSTICKY = 12;
  // status bit positions; classes voltage, temperature, charge follow in order
  localparam int ST_CELL_GONE = 3;
  localparam int ST_VMIN = 8;
  localparam int ST_INSERT = 11;
  localparam int ST_VMAX = 12;
  localparam int ST_REMOVE = 15;
  // shutdown delay register fields
  localparam int DLY_THR_LSB = 13;
  localparam int DLY_CNT_SHIFT = 3;
  localparam logic [15:0] DLY_BASE_TICKS = 16'h0100;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TASK_PERIOD_NS = 175800000;
  localparam int unsigned BIAS_PERIOD_NS = 1400000000;
  localparam int unsigned TASK_PERIOD_CYCLES = TASK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned BIAS_PERIOD_CYCLES = BIAS_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [2:0] BIAS_PULSE_CYCLES = 3'h4;
  typedef enum logic {AASC_ACTIVE, AASC_SHUTDOWN} aasc_mode_t;
endpackage

// [common/aasc_tick_if.sv]
// task and bias tick signals between timer and control logic
`timescale 1ns/1ps
interface aasc_tick_if;
  logic run;
  logic task_tick;
  logic bias_tick;
  modport gen (input run, output task_tick, output bias_tick);
  modport user (output run, input task_tick, input bias_tick);
endinterface

// [hdl/aasc_limit_cmp.sv]
// upper and lower byte limit comparator
`timescale 1ns/1ps
module aasc_limit_cmp #(
  parameter bit SIGNED_CMP = 1'b0
) (
  // measured value and limits
  input wire logic [7:0] value_in,
  input wire logic [15:0] limits_in,
  // violations
  output logic over_out,
  output logic under_out
);
  always_comb begin
    if (SIGNED_CMP) begin
      over_out = $signed(value_in) > $signed(limits_in[15:8]);
      under_out = $signed(value_in) < $signed(limits_in[7:0]);
    end else begin
      over_out = value_in > limits_in[15:8];
      under_out = value_in < limits_in[7:0];
    end
  end
endmodule

// [hdl/aasc_tick_gen.sv]
// task period and bias period tick generator
`timescale 1ns/1ps
module aasc_tick_gen import aasc_pkg::*; #(
  parameter int unsigned TASK_CYCLES = TASK_PERIOD_CYCLES,
  parameter int unsigned BIAS_CYCLES = BIAS_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // ticks
  aasc_tick_if.gen tick
);
  typedef struct packed {
    logic [31:0] task_cnt;
    logic [31:0] bias_cnt;
    logic task_tick;
    logic bias_tick;
  } aasc_tick_state_t;
  aasc_tick_state_t st;
  aasc_tick_state_t next_st;

  // counters hold still while in shutdown, as the whole task loop stops
  always_comb begin
    next_st = st;
    next_st.task_tick = 1'b0;
    next_st.bias_tick = 1'b0;
    if (tick.run) begin
      if (st.task_cnt >= 32'(TASK_CYCLES - 1)) begin
        next_st.task_cnt = 32'h0;
        next_st.task_tick = 1'b1;
      end else begin
        next_st.task_cnt = st.task_cnt + 32'h1;
      end
      if (st.bias_cnt >= 32'(BIAS_CYCLES - 1)) begin
        next_st.bias_cnt = 32'h0;
        next_st.bias_tick = 1'b1;
      end else begin
        next_st.bias_cnt = st.bias_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick.task_tick = st.task_tick;
  assign tick.bias_tick = st.bias_tick;
endmodule

// [hdl/aasc_core.sv]
// alert pin, threshold status and shutdown mode control
//
// Contract
// [RQ1] shutdown: any bus line edge wakes
// [RQ2] alert edge wakes per shutdown settings
// [RQ3] alert pin is open drain only
// [RQ4] removal, insertion, threshold alerts by enables
// [RQ5] insert/removal alerts stay until software clear
// [RQ6] voltage limits, 20mV steps, reset FF00h
// [RQ7] signed temperature limits, reset 7F80h
// [RQ8] charge limits on selected source, FF00h
// [RQ9] config writes act within one task
// [RQ10] alert enable gates pin, not flags
// [RQ11] force_bias holds bias on, fast removal
// [RQ12] auto bias pulse and measure each 1.4s
// [RQ13] held alert input shuts down, release wakes
// [RQ14] bus idle low shuts down, edge wakes
// [RQ15] no bus/removal shutdown: any edge wakes
// [RQ16] shutdown_request shuts down, self-clears on exit
// [RQ17] host_temp_select picks temperature source
// [RQ18] aux measure needs channel and bias enables
// [RQ19] persistent removal shuts down, insertion wakes
// [RQ20] alert_polarity sets pin active level
// [RQ21] per-class sticky or self-clearing threshold alerts
// [RQ22] host writes reserved config bits as zero
// [RQ23] delay is task period times 2^(8+thr)
// [RQ24] insert flag holds until software clears
// [RQ25] alert is OR of enabled pending sources
`timescale 1ns/1ps
module aasc_core import aasc_pkg::*; #(
  parameter int unsigned TASK_CYCLES = TASK_PERIOD_CYCLES,
  parameter int unsigned BIAS_CYCLES = BIAS_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // register access from the bus slave
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  // bus line levels
  input wire logic scl_in,
  input wire logic sda_in,
  // alert pin
  input wire logic alert_pin_in,
  output logic alert_pin_out,
  output logic alert_pin_oe_out,
  // auxiliary sense and bias
  input wire logic aux_removed_in,
  output logic bias_output_out,
  output logic aux_measure_out,
  // measurements
  input wire logic [7:0] vcell_in,
  input wire logic [7:0] temp_conv_in,
  input wire logic temp_conv_valid_in,
  input wire logic [31:0] soc_values_in,
  input wire logic [1:0] soc_source_select_in,
  // power mode
  output logic shutdown_out
);
  typedef struct packed {
    aasc_mode_t mode;
    logic [15:0] voltage_alert_limits;
    logic [15:0] temperature_alert_limits;
    logic [15:0] charge_alert_limits;
    logic [15:0] cfg;
    logic [15:0] status;
    logic [2:0] thr;
    logic [15:0] dly_cnt;
    logic [7:0] temp;
    logic cell_present;
    logic [2:0] bias_cnt;
    logic scl_q;
    logic sda_q;
    logic alert_q;
    logic removed_q;
    logic [15:0] rdata;
  } aasc_state_t;

  aasc_state_t st;
  aasc_state_t next_st;
  aasc_tick_if tick ();

  logic [7:0] cls_val [3];
  logic [15:0] cls_lim [3];
  logic [2:0] over;
  logic [2:0] under;
  logic active;
  logic force_bias;
  logic auto_bias_en;
  logic polarity;
  logic alert_pin_active;
  logic alert_active;
  logic thr_pending;
  logic shutdown_request_trigger;
  logic wake;
  logic bus_edge;
  logic alert_edge;
  logic measure_en;
  logic measure_now;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  function automatic logic [15:0] dly_limit(input logic [2:0] thr);
    dly_limit = DLY_BASE_TICKS << thr;
  endfunction

  aasc_tick_gen #(
    .TASK_CYCLES(TASK_CYCLES),
    .BIAS_CYCLES(BIAS_CYCLES)
  ) u_tick (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .tick(tick.gen)
  );

  assign tick.run = active;
  assign active = (st.mode == AASC_ACTIVE);

  // class order: voltage, temperature, charge state
  assign cls_val[0] = vcell_in; // [RQ6]
  assign cls_val[1] = st.temp; // [RQ7]
  assign cls_val[2] = soc_values_in[{soc_source_select_in, 3'b000} +: 8]; // [RQ8]
  assign cls_lim[0] = st.voltage_alert_limits;
  assign cls_lim[1] = st.temperature_alert_limits;
  assign cls_lim[2] = st.charge_alert_limits;

  // an all-ones max or all-zero min (7Fh and 80h when signed) can never be crossed, so resets disable both
  for (genvar c = 0; c < 3; c++) begin : g_cmp
    aasc_limit_cmp #(
      .SIGNED_CMP(c == 1)
    ) u_cmp (
      .value_in(cls_val[c]),
      .limits_in(cls_lim[c]),
      .over_out(over[c]),
      .under_out(under[c])
    );
  end

  // config acts from the cycle after the write, well inside a task period
  assign force_bias = st.cfg[CFG_FORCE_BIAS]; // [RQ9]
  assign auto_bias_en = st.cfg[CFG_AUTO_BIAS];
  assign polarity = st.cfg[CFG_POLARITY];
  assign alert_pin_active = polarity ? alert_pin_in : !alert_pin_in; // [RQ20]

  assign measure_en = st.cfg[CFG_TEMP_EN] && (auto_bias_en || force_bias); // [RQ18]
  assign measure_now = force_bias ? tick.task_tick : (st.bias_cnt == 3'h1);

  assign thr_pending = |st.status[ST_VMIN +: 3] || |st.status[ST_VMAX +: 3];
  assign alert_active = (st.cfg[CFG_REM_ALERT] && st.status[ST_REMOVE]) // [RQ4]
    || (st.cfg[CFG_INS_ALERT] && st.status[ST_INSERT])
    || (st.cfg[CFG_THR_ALERT] && thr_pending); // [RQ10] [RQ25]

  assign shutdown_request_trigger = st.cfg[CFG_SHUTDOWN_REQUEST_REQ] // [RQ16]
    || (st.cfg[CFG_REM_SHUTDOWN_REQUEST] && !st.cell_present) // [RQ19]
    || (st.cfg[CFG_BUS_SHUTDOWN_REQUEST] && !scl_in && !sda_in) // [RQ14]
    || (st.cfg[CFG_ALERT_SHUTDOWN_REQUEST] && alert_pin_active); // [RQ13]

  assign bus_edge = (scl_in != st.scl_q) || (sda_in != st.sda_q); // [RQ1]
  assign alert_edge = (alert_pin_in != st.alert_q)
    && (st.cfg[CFG_ALERT_SHUTDOWN_REQUEST] || !st.cfg[CFG_BUS_SHUTDOWN_REQUEST]); // [RQ2] [RQ15]
  assign wake = bus_edge || alert_edge
    || (st.cfg[CFG_REM_SHUTDOWN_REQUEST] && st.removed_q && !aux_removed_in); // [RQ19]

  always_comb begin
    next_st = st;
    next_st.scl_q = scl_in;
    next_st.sda_q = sda_in;
    next_st.alert_q = alert_pin_in;
    next_st.removed_q = aux_removed_in;

    // host register writes, taken only while active
    if (active && reg_wr_in) begin
      if (hit(reg_addr_in, ADDR_VOLTAGE_ALERT_LIMITS)) begin
        next_st.voltage_alert_limits = reg_wdata_in; // [RQ6]
      end
      if (hit(reg_addr_in, ADDR_TEMPERATURE_ALERT_LIMITS)) begin
        next_st.temperature_alert_limits = reg_wdata_in; // [RQ7]
      end
      if (hit(reg_addr_in, ADDR_CHARGE_ALERT_LIMITS)) begin
        next_st.charge_alert_limits = reg_wdata_in; // [RQ8]
      end
      if (hit(reg_addr_in, ADDR_CFG)) begin
        // the top bit is reserved; it is kept zero whatever the host sends
        next_st.cfg = reg_wdata_in & CFG_WMASK; // [RQ9] [RQ22]
      end
      if (hit(reg_addr_in, ADDR_SHUTDOWN_REQUEST_DLY)) begin
        next_st.thr = reg_wdata_in[DLY_THR_LSB +: 3];
      end
      if (hit(reg_addr_in, ADDR_TEMP) && st.cfg[CFG_HOST_TEMP]) begin
        next_st.temp = reg_wdata_in[7:0]; // [RQ17]
      end
    end

    // converted aux readings only land when the host is not the source
    if (!st.cfg[CFG_HOST_TEMP] && measure_en && temp_conv_valid_in) begin
      next_st.temp = temp_conv_in; // [RQ17]
    end

    // software clears a status bit by writing it zero; a new event wins
    if (active && reg_wr_in && hit(reg_addr_in, ADDR_STATUS)) begin
      next_st.status = st.status & reg_wdata_in;
    end
    for (int c = 0; c < 3; c++) begin
      if (st.cfg[CFG_VSTICKY + c]) begin
        next_st.status[ST_VMIN + c] = next_st.status[ST_VMIN + c] | under[c]; // [RQ21]
        next_st.status[ST_VMAX + c] = next_st.status[ST_VMAX + c] | over[c];
      end else begin
        next_st.status[ST_VMIN + c] = under[c]; // [RQ21]
        next_st.status[ST_VMAX + c] = over[c];
      end
    end

    // bias pulse every bias period; force_bias keeps the switch on instead
    if (active && auto_bias_en && !force_bias && tick.bias_tick) begin
      next_st.bias_cnt = BIAS_PULSE_CYCLES; // [RQ12]
    end else if (st.bias_cnt != 3'h0) begin
      next_st.bias_cnt = st.bias_cnt - 3'h1;
    end

    // presence is sampled at the end of a bias pulse, or every cycle when forced
    if (active && ((auto_bias_en && st.bias_cnt == 3'h1) || force_bias)) begin // [RQ11]
      if (aux_removed_in && st.cell_present) begin
        next_st.cell_present = 1'b0;
        next_st.status[ST_REMOVE] = 1'b1; // [RQ5]
      end else if (!aux_removed_in && !st.cell_present) begin
        next_st.cell_present = 1'b1;
        next_st.status[ST_INSERT] = 1'b1; // [RQ5] [RQ24]
      end
    end
    next_st.status[ST_CELL_GONE] = !next_st.cell_present;

    // power mode control
    case (st.mode)
      AASC_ACTIVE: begin
        if (!shutdown_request_trigger) begin
          next_st.dly_cnt = 16'h0;
        end else if (st.dly_cnt >= dly_limit(st.thr)) begin
          next_st.mode = AASC_SHUTDOWN; // [RQ23]
          next_st.dly_cnt = 16'h0;
        end else if (tick.task_tick) begin
          next_st.dly_cnt = st.dly_cnt + 16'h1; // [RQ23]
        end
      end
      AASC_SHUTDOWN: begin
        next_st.bias_cnt = 3'h0;
        if (wake) begin
          next_st.mode = AASC_ACTIVE; // [RQ1] [RQ2] [RQ13] [RQ14] [RQ15]
          next_st.cfg[CFG_SHUTDOWN_REQUEST_REQ] = 1'b0; // [RQ16]
        end
      end
      default: begin
        next_st.mode = AASC_ACTIVE;
      end
    endcase

    // read data is captured on the read strobe; unmapped offsets read zero
    if (reg_rd_in) begin
      if (hit(reg_addr_in, ADDR_STATUS)) begin
        next_st.rdata = st.status;
      end else if (hit(reg_addr_in, ADDR_VOLTAGE_ALERT_LIMITS)) begin
        next_st.rdata = st.voltage_alert_limits;
      end else if (hit(reg_addr_in, ADDR_TEMPERATURE_ALERT_LIMITS)) begin
        next_st.rdata = st.temperature_alert_limits;
      end else if (hit(reg_addr_in, ADDR_CHARGE_ALERT_LIMITS)) begin
        next_st.rdata = st.charge_alert_limits;
      end else if (hit(reg_addr_in, ADDR_TEMP)) begin
        next_st.rdata = {8'h00, st.temp};
      end else if (hit(reg_addr_in, ADDR_CFG)) begin
        next_st.rdata = st.cfg;
      end else if (hit(reg_addr_in, ADDR_SHUTDOWN_REQUEST_DLY)) begin
        next_st.rdata = {st.thr, 13'(st.dly_cnt >> DLY_CNT_SHIFT)};
      end else begin
        next_st.rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st.mode <= AASC_ACTIVE;
      st.voltage_alert_limits <= VOLTAGE_ALERT_LIMITS_RST;
      st.temperature_alert_limits <= TEMPERATURE_ALERT_LIMITS_RST;
      st.charge_alert_limits <= CHARGE_ALERT_LIMITS_RST;
      st.cfg <= CFG_RST;
      st.status <= STATUS_RST;
      st.thr <= THR_RST;
      st.dly_cnt <= 16'h0;
      st.temp <= TEMP_RST;
      st.cell_present <= 1'b1;
      st.bias_cnt <= 3'h0;
      st.scl_q <= 1'b1;
      st.sda_q <= 1'b1;
      st.alert_q <= 1'b1;
      st.removed_q <= 1'b0;
      st.rdata <= 16'h0000;
    end else begin
      st <= next_st;
    end
  end

  // open drain: only ever pulls low, the pull-up makes the high level
  assign alert_pin_out = 1'b0; // [RQ3]
  // as a shutdown input the pin is never driven
  assign alert_pin_oe_out = !st.cfg[CFG_ALERT_SHUTDOWN_REQUEST]
    && (polarity ? !alert_active : alert_active); // [RQ3] [RQ20] [RQ25]

  assign bias_output_out = active && (force_bias || st.bias_cnt != 3'h0); // [RQ11] [RQ12]
  assign aux_measure_out = active && measure_en && measure_now; // [RQ18]
  assign shutdown_out = !active;
  assign reg_rdata_out = st.rdata;
endmodule

// [testbench/aasc_monitor.sv]
// assertion checker for the alert and shutdown control ports
`timescale 1ns/1ps
module aasc_monitor import aasc_pkg::*; #(
  parameter int unsigned TASK_CYCLES = TASK_PERIOD_CYCLES,
  parameter int unsigned BIAS_CYCLES = BIAS_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_wdata_in,
  // pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic alert_pin_in,
  input wire logic alert_pin_out,
  input wire logic alert_pin_oe_out,
  input wire logic aux_removed_in,
  input wire logic bias_output_out,
  input wire logic shutdown_out
);
  // shadow of config and delay field, rebuilt from observed writes
  logic [15:0] cfg;
  logic [2:0] thr;
  logic trig;
  int unsigned trig_cnt;
  int unsigned lo;
  int unsigned hi;
  // removal counts only with force_bias, the way the bench drives it
  assign trig = cfg[CFG_SHUTDOWN_REQUEST_REQ] | (cfg[CFG_BUS_SHUTDOWN_REQUEST] & !scl_in & !sda_in)
    | (cfg[CFG_ALERT_SHUTDOWN_REQUEST] & (alert_pin_in == cfg[CFG_POLARITY]))
    | (cfg[CFG_REM_SHUTDOWN_REQUEST] & cfg[CFG_FORCE_BIAS] & aux_removed_in);
  // tick phase is unknown, so the window is a few ticks wide
  assign lo = (255 * TASK_CYCLES) << thr;
  assign hi = (258 * TASK_CYCLES) << thr;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg <= CFG_RST;
      thr <= THR_RST;
      trig_cnt <= 0;
    end else begin
      if (reg_wr_in && !shutdown_out && reg_addr_in == ADDR_CFG) begin
        cfg <= reg_wdata_in & CFG_WMASK;
      end else if (shutdown_out) begin
        cfg[CFG_SHUTDOWN_REQUEST_REQ] <= 1'b0;
      end
      if (reg_wr_in && !shutdown_out && reg_addr_in == ADDR_SHUTDOWN_REQUEST_DLY) begin
        thr <= reg_wdata_in[15:13];
      end
      trig_cnt <= (trig && !shutdown_out) ? trig_cnt + 1 : 0;
    end
  end
  default clocking dc @(posedge clock_in);
  endclocking
  default disable iff (!arst_n_in);
  sequence s_pulse;
    bias_output_out [*4] ##1 !bias_output_out;
  endsequence
  sequence s_wake;
    ##[1:3] !shutdown_out;
  endsequence
  a_pin_open_drain: assert property (alert_pin_out == 1'b0)
    else $error("alert pin data not low");
  a_bus_wake: assert property (shutdown_out && ($changed(scl_in) || $changed(sda_in))
    |-> s_wake) else $error("no wake on bus edge");
  a_pin_wake: assert property (shutdown_out && $changed(alert_pin_in)
    && (cfg[CFG_ALERT_SHUTDOWN_REQUEST] || !cfg[CFG_BUS_SHUTDOWN_REQUEST]) |-> s_wake)
    else $error("no wake on alert edge");
  a_removal_alert: assert property (!shutdown_out && cfg[CFG_REM_ALERT]
    && cfg[CFG_FORCE_BIAS] && !cfg[CFG_ALERT_SHUTDOWN_REQUEST] && !cfg[CFG_POLARITY]
    && $rose(aux_removed_in) |-> ##[1:2] alert_pin_oe_out) else $error("removal alert late");
  a_flag_sticky: assert property ($fell(alert_pin_oe_out) && $stable(cfg)
    && !cfg[CFG_THR_ALERT] && !cfg[CFG_POLARITY]
    |-> $past(reg_wr_in && reg_addr_in == ADDR_STATUS)) else $error("alert cleared itself");
  a_pin_input: assert property (cfg[CFG_ALERT_SHUTDOWN_REQUEST] |-> !alert_pin_oe_out)
    else $error("alert driven while input");
  a_bias_forced: assert property (cfg[CFG_FORCE_BIAS] && !shutdown_out |-> bias_output_out)
    else $error("forced bias off");
  a_bias_width: assert property ($rose(bias_output_out) && !cfg[CFG_FORCE_BIAS]
    |-> s_pulse) else $error("bias pulse width wrong");
  a_shutdown_request_early: assert property ($rose(shutdown_out) |-> trig_cnt >= lo)
    else $error("shutdown before delay");
  a_shutdown_request_late: assert property (!shutdown_out |-> trig_cnt <= hi)
    else $error("shutdown after delay");
endmodule
bind aasc_core aasc_monitor #(.TASK_CYCLES(TASK_CYCLES), .BIAS_CYCLES(BIAS_CYCLES)) mon_u (
  .clock_in(clock_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .scl_in(scl_in), .sda_in(sda_in),
  .alert_pin_in(alert_pin_in), .alert_pin_out(alert_pin_out),
  .alert_pin_oe_out(alert_pin_oe_out), .aux_removed_in(aux_removed_in),
  .bias_output_out(bias_output_out), .shutdown_out(shutdown_out));

// [testbench/aasc_host_model.sv]
// host side model: bus line levels and pulled-up alert wire
`timescale 1ns/1ps
module aasc_host_model (
  // controls from the bench
  input wire logic bus_low_in,
  input wire logic pin_low_in,
  // device alert driver
  input wire logic alert_oe_in,
  // wires seen by the device
  output logic scl_out,
  output logic sda_out,
  output logic alert_wire_out
);
  // released bus lines sit high on their pull-ups
  assign scl_out = !bus_low_in;
  assign sda_out = !bus_low_in;
  // open-drain wire: any party pulling low beats the pull-up
  assign alert_wire_out = !(alert_oe_in || pin_low_in);
endmodule

// [testbench/tb.sv]
// self-checking bench for the alert and shutdown control block
`timescale 1ns/1ps
module tb import aasc_pkg::*;;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic [15:0] reg_rdata_out;
  logic scl_in;
  logic sda_in;
  logic alert_pin_in;
  logic alert_pin_oe_out;
  logic aux_removed_in = 1'b0;
  logic bias_output_out;
  logic aux_measure_out;
  logic [7:0] vcell_in = 8'h50;
  logic [7:0] temp_conv_in = 8'h00;
  logic temp_conv_valid_in = 1'b0;
  logic [31:0] soc_values_in = 32'h0000_0000;
  logic [1:0] soc_source_select_in = 2'h0;
  logic shutdown_out;
  logic bus_low = 1'b0;
  logic pin_low = 1'b0;
  logic [15:0] rv;
  // removal shutdown needs force_bias so that presence is sampled
  logic [15:0] mode_cfg [4] = '{16'h0080, 16'h0040, 16'h0020, 16'h0408};
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  aasc_core #(.TASK_CYCLES(10), .BIAS_CYCLES(40)) dut_u (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .scl_in(scl_in), .sda_in(sda_in),
    .alert_pin_in(alert_pin_in), .alert_pin_out(), .alert_pin_oe_out(alert_pin_oe_out),
    .aux_removed_in(aux_removed_in), .bias_output_out(bias_output_out),
    .aux_measure_out(aux_measure_out),
    .vcell_in(vcell_in), .temp_conv_in(temp_conv_in), .temp_conv_valid_in(temp_conv_valid_in),
    .soc_values_in(soc_values_in), .soc_source_select_in(soc_source_select_in),
    .shutdown_out(shutdown_out));
  aasc_host_model host_u (.bus_low_in(bus_low), .pin_low_in(pin_low),
    .alert_oe_in(alert_pin_oe_out), .scl_out(scl_in), .sda_out(sda_in),
    .alert_wire_out(alert_pin_in));
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clock_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clock_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clock_in);
    reg_rd_in = 1'b0;
    rv = reg_rdata_out;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [15:0] e);
    rd(a);
    chk(nm, e, rv);
  endtask
  task automatic wait_sd(input logic v, input int lim);
    n = 0;
    while (shutdown_out !== v && n < lim) begin
      @(negedge clock_in);
      n++;
    end
  endtask
  initial begin
    forever #20 clock_in = ~clock_in;
  end
  // hang guard: whole run needs roughly 10500 cycles
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(negedge clock_in);
    arst_n_in = 1'b1;
    // kept short so no auto bias pulse is cut by the first config write
    chk_rd("voltage_alert_limits", ADDR_VOLTAGE_ALERT_LIMITS, 16'hFF00);
    chk_rd("temperature_alert_limits", ADDR_TEMPERATURE_ALERT_LIMITS, 16'h7F80);
    chk_rd("charge_alert_limits", ADDR_CHARGE_ALERT_LIMITS, 16'hFF00);
    chk_rd("cfg", ADDR_CFG, 16'h2350);
    chk_rd("unmapped", 8'h10, 16'h0000);
    $display("test reset values done");
    wr(ADDR_CFG, 16'h0000);
    wr(ADDR_VOLTAGE_ALERT_LIMITS, 16'h8010);
    vcell_in = 8'h90;
    rd(ADDR_STATUS);
    chk("vmax flag", 16'h1000, rv & 16'h1000);
    chk_pin("oe gated", 1'b0, alert_pin_oe_out);
    wr(ADDR_CFG, 16'h0004);
    chk_pin("oe thr", 1'b1, alert_pin_oe_out);
    wr(ADDR_CFG, 16'h0804);
    chk_pin("oe pol", 1'b0, alert_pin_oe_out);
    wr(ADDR_CFG, 16'h0004);
    vcell_in = 8'h50;
    repeat (2) @(negedge clock_in);
    chk_pin("oe auto clear", 1'b0, alert_pin_oe_out);
    wr(ADDR_CFG, 16'h1004);
    vcell_in = 8'h08;
    repeat (2) @(negedge clock_in);
    vcell_in = 8'h50;
    repeat (2) @(negedge clock_in);
    chk_pin("oe sticky", 1'b1, alert_pin_oe_out);
    wr(ADDR_STATUS, 16'h0000);
    chk_pin("oe sw clear", 1'b0, alert_pin_oe_out);
    wr(ADDR_VOLTAGE_ALERT_LIMITS, 16'hFF00);
    // signed compare: F0h is below the minimum, not above the maximum
    wr(ADDR_CFG, 16'h0100);
    wr(ADDR_TEMPERATURE_ALERT_LIMITS, 16'h0AF6);
    wr(ADDR_TEMP, 16'h00F0);
    rd(ADDR_STATUS);
    chk("temp signed", 16'h0200, rv & 16'h2200);
    wr(ADDR_TEMPERATURE_ALERT_LIMITS, 16'h7F80);
    wr(ADDR_CHARGE_ALERT_LIMITS, 16'h5000);
    soc_values_in = 32'h0060_0000;
    for (int s = 0; s < 4; s++) begin
      soc_source_select_in = s[1:0];
      repeat (2) @(negedge clock_in);
      rd(ADDR_STATUS);
      chk("smax flag", {1'b0, s == 2, 14'h0000}, rv & 16'h4000);
    end
    soc_values_in = 32'h0000_0000;
    wr(ADDR_CHARGE_ALERT_LIMITS, 16'hFF00);
    $display("test thresholds done");
    wr(ADDR_CFG, 16'h000B);
    chk_pin("bias forced", 1'b1, bias_output_out);
    aux_removed_in = 1'b1;
    repeat (2) @(negedge clock_in);
    chk_pin("oe removal", 1'b1, alert_pin_oe_out);
    aux_removed_in = 1'b0;
    repeat (2) @(negedge clock_in);
    rd(ADDR_STATUS);
    chk("cell flags", 16'h8800, rv & 16'h8800);
    chk_pin("oe held", 1'b1, alert_pin_oe_out);
    wr(ADDR_STATUS, 16'h0000);
    chk_pin("oe cleared", 1'b0, alert_pin_oe_out);
    $display("test cell events done");
    wr(ADDR_CFG, 16'h0210);
    n = 0;
    while (bias_output_out !== 1'b1 && n < 100) begin
      @(negedge clock_in);
      n++;
    end
    chk_pin("bias pulse", 1'b1, bias_output_out);
    repeat (3) @(negedge clock_in);
    chk_pin("aux measure", 1'b1, aux_measure_out);
    @(negedge clock_in);
    chk_pin("bias pulse end", 1'b0, bias_output_out);
    temp_conv_in = 8'h0C;
    temp_conv_valid_in = 1'b1;
    @(negedge clock_in);
    temp_conv_valid_in = 1'b0;
    wr(ADDR_TEMP, 16'h0055);
    chk_rd("aux temp", ADDR_TEMP, 16'h000C);
    $display("test auto bias done");
    wr(ADDR_SHUTDOWN_REQUEST_DLY, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CFG, mode_cfg[m]);
      bus_low = (m == 1);
      pin_low = (m == 2);
      aux_removed_in = (m == 3);
      wait_sd(1'b1, 4000);
      chk("shutdown_request delay", 16'h0001, {15'h0000, n >= 2540 && n <= 2600});
      wr(ADDR_VOLTAGE_ALERT_LIMITS, 16'h1234);
      if (m == 0) begin
        bus_low = 1'b1;
        @(negedge clock_in);
      end
      bus_low = 1'b0;
      pin_low = 1'b0;
      aux_removed_in = 1'b0;
      wait_sd(1'b0, 10);
      chk_pin("woken", 1'b0, shutdown_out);
      chk_rd("cfg after wake", ADDR_CFG, mode_cfg[m] & 16'hFF7F);
      chk_rd("write in shutdown", ADDR_VOLTAGE_ALERT_LIMITS, 16'hFF00);
    end
    $display("test shutdown done");
    close_out();
  end
endmodule
